//--- bench/io_output_pulse_sequencer_tb_top.sv
// bench top: apb master, scenarios and verdict for the output sequencer
`timescale 1ns/1ps
`default_nettype none
module io_output_pulse_sequencer_tb_top;
  import pulse_seq_pkg::*;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, io_activity, msg_ready, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_IN-1:0] in_pins, in_alarm;
  pin_drv_t [NUM_OUT-1:0] out_pins;
  msg_byte_t msg_out;
  int err_count, n_checks;

  io_output_pulse_sequencer u_io_output_pulse_sequencer (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_activity(io_activity),
    .in_pins(in_pins), .in_alarm(in_alarm), .out_pins(out_pins), .msg_out(msg_out),
    .msg_ready(msg_ready));
  msg_receiver u_msg_receiver (.ref_clk(ref_clk), .rst_n(rst_n), .msg_out(msg_out),
    .msg_ready(msg_ready));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [11:0] ca(input int n, input logic [11:0] off);
    return OFF_CH_BASE + OFF_CH_STRIDE * n[11:0] + off;
  endfunction

  task automatic wait_pin(input int c, input pin_drv_t exp);
    int n;
    n = 0;
    while (out_pins[c] !== exp && n < 100) begin
      settle();
      n++;
    end
    chk(out_pins[c], exp);
  endtask

  task automatic wait_msgs(input int cnt);
    int n;
    n = 0;
    while (u_msg_receiver.rx_n < cnt && n < 500) begin
      settle();
      n++;
    end
    chk(u_msg_receiver.rx_n, cnt);
  endtask

  task automatic msg_chk(input int b, input logic [7:0] t, input logic [7:0] num,
    input logic [7:0] al, input logic [7:0] st);
    logic [7:0] e [20];
    logic [47:0] mac;
    mac = 48'h5566_1122_3344;
    e = '{default: 8'h00};
    e[0] = t;
    e[1] = num;
    for (int k = 0; k < 6; k++) e[2 + k] = mac[47 - 8 * k -: 8];
    e[8] = al;
    e[9] = st;
    for (int i = 0; i < 20; i++) begin
      chk({24'h0, u_msg_receiver.rx[(b + i) % 256]}, {24'h0, e[i]});
    end
  endtask

  task automatic test_defaults();
    logic [11:0] w [3];
    w = '{OFF_ACT_W, OFF_INACT_W, OFF_DELAY};
    chk(out_pins, 32'h0);
    rdc(ca(0, OFF_CTRL), 32'h0);
    rdc(ca(0, OFF_COUNT), 32'h1);
    rdc(OFF_FS_CFG, 32'h1E);
    apb(1'b1, OFF_FS_CFG, 32'h0);
    rdc(OFF_FS_CFG, 32'h1E);
    for (int i = 0; i < 3; i++) begin
      rdc(ca(0, w[i]), 32'h1);
      apb(1'b1, ca(0, w[i]), 32'h0);
      rdc(ca(0, w[i]), 32'h1);
      apb(1'b1, ca(0, w[i]), 32'h270F);
      rdc(ca(0, w[i]), 32'h270F);
    end
    rdc(ca(0, OFF_CMD), 32'h0);
    rdc(12'h0FC, 32'h0);
    chk(err, 1'b1);
  endtask

  task automatic test_drive();
    pin_drv_t idle [3];
    pin_drv_t on [3];
    idle = '{2'b00, 2'b00, 2'b10};
    on = '{2'b10, 2'b01, 2'b01};
    for (int d = 0; d < 3; d++) begin
      apb(1'b1, ca(1, OFF_CTRL), 32'(d));
      settle();
      chk(out_pins[1], idle[d]);
      apb(1'b1, ca(1, OFF_CMD), 32'h3);
      settle();
      chk(out_pins[1], on[d]);
      chk(out_pins[0], 2'b00);
      rdc(ca(1, OFF_STATUS), 32'h1);
      apb(1'b1, ca(1, OFF_CMD), 32'h2);
      settle();
      chk(out_pins[1], idle[d]);
    end
  endtask

  task automatic test_modes();
    apb(1'b1, ca(2, OFF_CTRL), 32'h4);
    apb(1'b1, ca(2, OFF_CMD), 32'h1);
    settle();
    chk(out_pins[2], 2'b10);
    apb(1'b1, ca(2, OFF_CMD), 32'h2);
    settle();
    chk(out_pins[2], 2'b00);
    apb(1'b1, ca(2, OFF_CTRL), 32'h8);
    apb(1'b1, ca(2, OFF_CMD), 32'h1);
    repeat (500) settle();
    chk(out_pins[2], 2'b00);
    apb(1'b1, ca(2, OFF_CTRL), 32'hC);
    apb(1'b1, ca(2, OFF_CMD), 32'h1);
    settle();
    chk(out_pins[2], 2'b10);
    repeat (500) settle();
    chk(out_pins[2], 2'b10);
    apb(1'b1, ca(2, OFF_CMD), 32'h2);
    settle();
    chk(out_pins[2], 2'b00);
  endtask

  task automatic test_follow();
    int b;
    b = u_msg_receiver.rx_n;
    apb(1'b1, ca(3, OFF_CTRL), 32'h280);
    @(posedge ref_clk);
    in_pins[1] <= 1'b1;
    wait_pin(3, 2'b10);
    @(posedge ref_clk);
    in_pins[1] <= 1'b0;
    wait_pin(3, 2'b00);
    wait_msgs(b + 40);
  endtask

  task automatic test_msgs();
    int b;
    apb(1'b1, OFF_MAC_LO, 32'h1122_3344);
    apb(1'b1, OFF_MAC_HI, 32'h0000_5566);
    b = u_msg_receiver.rx_n;
    @(posedge ref_clk);
    in_pins[2] <= 1'b1;
    in_alarm[2] <= 1'b1;
    wait_msgs(b + 20);
    msg_chk(b, 8'h00, 8'h03, 8'h01, 8'h01);
    @(posedge ref_clk);
    in_pins[0] <= 1'b1;
    in_pins[5] <= 1'b1;
    wait_msgs(b + 60);
    msg_chk(b + 20, 8'h00, 8'h01, 8'h00, 8'h01);
    msg_chk(b + 40, 8'h01, 8'h06, 8'h00, 8'h01);
    chk(u_msg_receiver.kept, u_msg_receiver.rx_n / 20);
  endtask

  // reset, scenarios, verdict
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    io_activity = 1'b0;
    in_pins = '0;
    in_alarm = '0;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_defaults();
    test_drive();
    test_modes();
    test_follow();
    test_msgs();
    finish_test();
  end
endmodule

bind io_output_pulse_sequencer pulse_seq_props u_pulse_seq_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .out_pins(out_pins), .msg_out(msg_out), .msg_ready(msg_ready));
`default_nettype wire

//--- bench/msg_receiver.sv
// far-side model: status message receiver that stalls one cycle in three
`timescale 1ns/1ps
`default_nettype none
module msg_receiver (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pulse_seq_pkg::msg_byte_t msg_out,
  output logic msg_ready
);
  import pulse_seq_pkg::*;
  logic [7:0] rx [0:255];
  logic [7:0] type_reg;
  logic [1:0] stall_reg;
  int rx_n;
  int kept;
  assign msg_ready = stall_reg != 2'h2;
  // store every byte; type byte latched first, messages of unknown type stored but not counted in kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= 2'h0;
      rx_n <= 0;
      kept <= 0;
    end else begin
      stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
      if (msg_out.valid && msg_ready) begin
        rx[rx_n[7:0]] <= msg_out.data;
        rx_n <= rx_n + 1;
        if (rx_n % 20 == 0) type_reg <= msg_out.data;
        if (msg_out.last && type_reg <= MSG_SERIAL) kept <= kept + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/pulse_seq_props.sv
// checker: port properties of the output sequencer
`timescale 1ns/1ps
`default_nettype none
module pulse_seq_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pulse_seq_pkg::pin_drv_t [pulse_seq_pkg::NUM_OUT-1:0] out_pins,
  input wire pulse_seq_pkg::msg_byte_t msg_out,
  input wire logic msg_ready
);
  import pulse_seq_pkg::*;
  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic [NUM_OUT-1:0] fight;
  logic acc;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // byte index inside the current message
  assign acc = msg_out.valid && msg_ready;
  assign idx_next = !acc ? idx_reg : (msg_out.last ? 5'h00 : idx_reg + 5'h01);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= 5'h00;
    end else begin
      idx_reg <= idx_next;
    end
  end
  // channels that ground and drive at once
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_fight
    assign fight[i] = out_pins[i].pull_low & out_pins[i].drive_high;
  end
  sequence stall_s;
    msg_out.valid && !msg_ready;
  endsequence
  sequence held_s;
    msg_out.valid && $stable(msg_out.data) && $stable(msg_out.last);
  endsequence
  byte_hold_a: assert property (stall_s |=> held_s)
    else $error("byte not held");
  msg_len_a: assert property (msg_out.valid |-> msg_out.last == (idx_reg == 5'h13))
    else $error("bad message length");
  type_byte_a: assert property (msg_out.valid && idx_reg == 5'h00 |-> msg_out.data <= 8'h01)
    else $error("bad type byte");
  in_number_a: assert property (msg_out.valid && idx_reg == 5'h01 |-> msg_out.data inside {[8'h01:8'h07]})
    else $error("bad input number");
  alarm_byte_a: assert property (msg_out.valid && idx_reg == 5'h08 |-> msg_out.data <= 8'h01)
    else $error("bad alarm byte");
  status_byte_a: assert property (msg_out.valid && idx_reg == 5'h09 |-> msg_out.data <= 8'h01)
    else $error("bad status byte");
  reserved_zero_a: assert property (msg_out.valid && idx_reg >= 5'h0A |-> msg_out.data == 8'h00)
    else $error("reserved byte set");
  no_fight_a: assert property (fight == '0)
    else $error("line grounded and driven");
endmodule
`default_nettype wire

//--- hdl/io_output_pulse_sequencer.sv
// top: apb registers, tick divider, failsafe timer, outputs, input status messages
// Functional notes
// R01: sink type grounds line when active, default
// R02: source type drives voltage when active
// R03: sink-and-source: ground inactive, voltage active
// R04: manual mode follows activate/deactivate only
// R05: pulse mode alternates active/inactive after activate
// R06: continuous pulse runs until stopped
// R07: counted pulse emits configured sequences, default one
// R08: inactive width times 100 ms
// R09: active width times 100 ms
// R10: delayed activation waits then activates
// R11: delayed deactivation goes inactive after delay
// R12: delay setting times 100 ms
// R13: failsafe none leaves output unchanged
// R14: failsafe forces active or inactive
// R15: failsafe timeout 1-9999 seconds, default 30; code accepts any nonzero 14-bit value, up to 16383
// R16: each input change sends its own message
// R17: message is 20 bytes, last ten reserved
// R18: field order type, number, address, alarm, status
// R19: type 0 digital, 1 serial signal
// R20: numbers 1-4 digital, 5-7 serial signals
// R21: alarm byte 0 clear, 1 alarm
// R22: status byte 0/1, reserved bytes zero
// R23: receiver drops unknown types, skips block
// R24: output follows at most one input
// R25: after last count stay inactive
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module io_output_pulse_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic io_activity,
  input wire logic [pulse_seq_pkg::NUM_IN-1:0] in_pins,
  input wire logic [pulse_seq_pkg::NUM_IN-1:0] in_alarm,
  output pulse_seq_pkg::pin_drv_t [pulse_seq_pkg::NUM_OUT-1:0] out_pins,
  output pulse_seq_pkg::msg_byte_t msg_out,
  input wire logic msg_ready
);
  import pulse_seq_pkg::*;

  // apb decode
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic [11:0] ch_off = paddr - OFF_CH_BASE;
  wire logic in_ch = (paddr >= OFF_CH_BASE) &&
    (paddr < OFF_CH_BASE + OFF_CH_STRIDE * 12'(NUM_OUT));
  wire logic [1:0] ch_sel = ch_off[7:6];
  wire logic [11:0] reg_off = {6'h00, ch_off[5:0]};
  wire logic glob_hit = (paddr == OFF_FS_CFG) || (paddr == OFF_MAC_LO) ||
    (paddr == OFF_MAC_HI) || (paddr == OFF_INCFG);
  wire logic ch_hit = in_ch && reg_off <= OFF_STATUS && reg_off[1:0] == 2'b00;
  assign pready = 1'b1;
  assign pslverr = acc && !(glob_hit || ch_hit);

  ch_cfg_t cfg_reg [NUM_OUT];
  logic [NUM_OUT-1:0] act_pulse, deact_pulse, active;
  logic fs_en_reg;
  logic [13:0] fs_sec_reg;
  logic [47:0] mac_reg;
  logic [NUM_IN-1:0] in_inv_reg;

  // 100 ms tick divider
  logic [23:0] div_reg;
  wire logic tick = (div_reg == 24'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) div_reg <= 24'h000000;
    else div_reg <= tick ? 24'h000000 : div_reg + 24'h000001;
  end

  // input synchronisers and change detect
  logic [NUM_IN-1:0] in_s1, in_s2, in_prev, al_s1, al_s2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= '0;
      in_s2 <= '0;
      in_prev <= '0;
      al_s1 <= '0;
      al_s2 <= '0;
    end else begin
      in_s1 <= in_pins;
      in_s2 <= in_s1;
      in_prev <= in_s2;
      al_s1 <= in_alarm;
      al_s2 <= al_s1;
    end
  end
  wire logic [NUM_IN-1:0] in_state = in_s2 ^ in_inv_reg;
  wire logic [NUM_IN-1:0] in_chg = in_s2 ^ in_prev;

  // failsafe inactivity timer in seconds
  logic act_s1, act_s2;
  logic [3:0] sec_div_reg;
  logic [13:0] fs_cnt_reg;
  wire logic sec_tick = tick && (sec_div_reg == 4'(SEC_TICKS - 1));
  wire logic activity = act_s2 || (|in_chg) || wr;
  wire logic fs_fire = fs_en_reg && sec_tick && !activity &&
    (fs_cnt_reg + 14'h0001 >= fs_sec_reg); // R15
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
      sec_div_reg <= 4'h0;
      fs_cnt_reg <= 14'h0000;
    end else begin
      act_s1 <= io_activity;
      act_s2 <= act_s1;
      if (tick) sec_div_reg <= sec_tick ? 4'h0 : sec_div_reg + 4'h1;
      if (activity || fs_fire || !fs_en_reg) fs_cnt_reg <= 14'h0000;
      else if (sec_tick) fs_cnt_reg <= fs_cnt_reg + 14'h0001;
    end
  end

  // per-channel registers, commands and sequencers
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gen_ch
      wire logic sel = wr && ch_hit && ch_sel == 2'(g);
      wire logic cmd_wr = sel && reg_off == OFF_CMD;
      // follow one local input: source index in 1..7 selects in_state bit
      wire logic [2:0] src = cfg_reg[g].follow_src;
      wire logic src_ok = cfg_reg[g].follow_en && src != 3'h0; // R24
      wire logic [2:0] src_i = src - 3'h1;
      wire logic f_chg = src_ok && in_chg[src_i];
      wire logic f_lvl = in_state[src_i];
      assign act_pulse[g] = (cmd_wr && pwdata[0]) || (f_chg && f_lvl);
      assign deact_pulse[g] = (cmd_wr && pwdata[1]) || (f_chg && !f_lvl);

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_reg[g] <= '{DRV_SINK, OUT_MANUAL, 1'b0, FS_NONE, 1'b0, 3'h0,
            WIDTH_RST, WIDTH_RST, DELAY_RST, COUNT_RST}; // R01 R07 R08 R09 R12 R13
        end else if (sel) begin
          if (reg_off == OFF_CTRL) begin
            cfg_reg[g].drive <= drive_t'(pwdata[1:0]);
            cfg_reg[g].mode <= out_mode_t'(pwdata[3:2]);
            cfg_reg[g].counted <= pwdata[4];
            cfg_reg[g].fs <= fs_act_t'(pwdata[6:5]);
            cfg_reg[g].follow_en <= pwdata[7];
            cfg_reg[g].follow_src <= pwdata[10:8];
          end
          if (reg_off == OFF_ACT_W && pwdata[13:0] != 14'h0) cfg_reg[g].act_w <= pwdata[13:0];
          if (reg_off == OFF_INACT_W && pwdata[13:0] != 14'h0) cfg_reg[g].inact_w <= pwdata[13:0];
          if (reg_off == OFF_DELAY && pwdata[13:0] != 14'h0) cfg_reg[g].delay <= pwdata[13:0];
          if (reg_off == OFF_COUNT && pwdata[13:0] != 14'h0) cfg_reg[g].count <= pwdata[13:0];
        end
      end

      out_channel u_ch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .cfg(cfg_reg[g]),
        .act_cmd(act_pulse[g]),
        .deact_cmd(deact_pulse[g]),
        .fs_fire(fs_fire), // R13 R14
        .active(active[g]),
        .pin(out_pins[g])
      );
    end
  endgenerate

  // global registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_en_reg <= 1'b0;
      fs_sec_reg <= FS_SEC_RST; // R15
      mac_reg <= MAC_RST;
      in_inv_reg <= '0;
    end else if (wr) begin
      if (paddr == OFF_FS_CFG) begin
        fs_en_reg <= pwdata[16];
        if (pwdata[13:0] != 14'h0) fs_sec_reg <= pwdata[13:0];
      end
      if (paddr == OFF_MAC_LO) mac_reg[31:0] <= pwdata;
      if (paddr == OFF_MAC_HI) mac_reg[47:32] <= pwdata[15:0];
      if (paddr == OFF_INCFG) in_inv_reg <= pwdata[NUM_IN-1:0];
    end
  end

  // read mux
  wire ch_cfg_t rc = cfg_reg[ch_sel];
  logic [31:0] rd_ch, rd_glob;
  assign rd_ch = (reg_off == OFF_CTRL) ? {21'h0, rc.follow_src, rc.follow_en, rc.fs,
      rc.counted, rc.mode, rc.drive} :
    (reg_off == OFF_ACT_W) ? {18'h0, rc.act_w} :
    (reg_off == OFF_INACT_W) ? {18'h0, rc.inact_w} :
    (reg_off == OFF_DELAY) ? {18'h0, rc.delay} :
    (reg_off == OFF_COUNT) ? {18'h0, rc.count} :
    (reg_off == OFF_STATUS) ? {31'h0, active[ch_sel]} : 32'h00000000;
  assign rd_glob = (paddr == OFF_FS_CFG) ? {15'h0, fs_en_reg, 2'h0, fs_sec_reg} :
    (paddr == OFF_MAC_LO) ? mac_reg[31:0] :
    (paddr == OFF_MAC_HI) ? {16'h0, mac_reg[47:32]} :
    (paddr == OFF_INCFG) ? {9'h0, al_s2, 9'h0, in_state} : 32'h00000000;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) prdata <= ch_hit ? rd_ch : rd_glob;
  end

  // pending changes, one message per input
  logic [NUM_IN-1:0] pend_reg;
  logic busy_reg;
  logic [2:0] cur_reg;
  logic [4:0] idx_reg;
  logic [6:0] snap_st, snap_al;
  logic [2:0] pick;
  always_comb begin
    pick = 3'h0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (pend_reg[i]) pick = 3'(i);
    end
  end
  wire logic start = !busy_reg && |pend_reg;
  wire logic byte_go = busy_reg && (!msg_out.valid || msg_ready);
  wire logic [2:0] num = cur_reg + 3'h1; // R20
  logic [7:0] byte_val;
  always_comb begin
    unique case (idx_reg)
      5'd0: byte_val = (cur_reg < 3'h4) ? MSG_DIGITAL : MSG_SERIAL; // R19
      5'd1: byte_val = {5'h00, num}; // R18 R20
      5'd2: byte_val = mac_reg[47:40];
      5'd3: byte_val = mac_reg[39:32];
      5'd4: byte_val = mac_reg[31:24];
      5'd5: byte_val = mac_reg[23:16];
      5'd6: byte_val = mac_reg[15:8];
      5'd7: byte_val = mac_reg[7:0];
      5'd8: byte_val = {7'h00, snap_al[cur_reg]}; // R21
      5'd9: byte_val = {7'h00, snap_st[cur_reg]}; // R22
      default: byte_val = 8'h00; // R17 R22
    endcase
  end

  // message stream sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= '0;
      busy_reg <= 1'b0;
      cur_reg <= 3'h0;
      idx_reg <= 5'h00;
      snap_st <= '0;
      snap_al <= '0;
      msg_out <= '0;
    end else begin
      pend_reg <= (pend_reg & ~((start ? 7'(1) << pick : 7'h00))) | in_chg; // R16
      if (start) begin
        busy_reg <= 1'b1;
        cur_reg <= pick;
        idx_reg <= 5'h00;
        snap_st <= in_state;
        snap_al <= al_s2;
      end else if (byte_go) begin
        msg_out <= '{1'b1, idx_reg == 5'(MSG_BYTES - 1), byte_val}; // R17
        idx_reg <= idx_reg + 5'h01;
        if (idx_reg == 5'(MSG_BYTES - 1)) busy_reg <= 1'b0;
      end
      // drop valid once taken, also when the next message starts, so no byte repeats
      if (!byte_go && msg_ready) msg_out.valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hdl/out_channel.sv
// one output channel sequencer: manual, pulse, delayed modes, failsafe
`timescale 1ns/1ps
`default_nettype none
module out_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire pulse_seq_pkg::ch_cfg_t cfg,
  input wire logic act_cmd,
  input wire logic deact_cmd,
  input wire logic fs_fire,
  output logic active,
  output pulse_seq_pkg::pin_drv_t pin
);
  import pulse_seq_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ON = 3'b001, S_P_ON = 3'b010, S_P_OFF = 3'b011,
    S_WAIT_ON = 3'b100, S_WAIT_OFF = 3'b101
  } st_t;

  st_t state_reg, state_next;
  logic [13:0] tmr_reg, tmr_next;
  logic [13:0] cnt_reg, cnt_next;
  logic active_reg;

  wire logic tmr_done = tick && (tmr_reg <= 14'h0001);
  wire logic tmr_dec = tick && !tmr_done;

  // next state of the sequencer
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_dec ? tmr_reg - 14'h0001 : tmr_reg;
    cnt_next = cnt_reg;
    if (fs_fire && cfg.fs == FS_ACT) begin
      state_next = S_ON; // R14
    end else if (fs_fire && cfg.fs == FS_DEACT) begin
      state_next = S_IDLE; // R14
    end else if (act_cmd) begin
      unique case (cfg.mode)
        OUT_MANUAL: state_next = S_ON; // R04
        OUT_PULSE: begin
          state_next = S_P_ON; // R05
          tmr_next = cfg.act_w;
          cnt_next = cfg.count;
        end
        OUT_DLY_ACT: begin
          state_next = S_WAIT_ON; // R10
          tmr_next = cfg.delay;
        end
        OUT_DLY_DEACT: begin
          state_next = S_WAIT_OFF; // R11
          tmr_next = cfg.delay;
        end
      endcase
    end else if (deact_cmd) begin
      state_next = S_IDLE; // R04
    end else begin
      unique case (state_reg)
        S_IDLE, S_ON: state_next = state_reg; // R25
        S_P_ON: if (tmr_done) begin
          state_next = S_P_OFF; // R09
          tmr_next = cfg.inact_w;
        end
        S_P_OFF: if (tmr_done) begin
          if (cfg.counted && cnt_reg <= 14'h0001) begin
            state_next = S_IDLE; // R07 R25
          end else begin
            state_next = S_P_ON; // R06 R08
            tmr_next = cfg.act_w;
            cnt_next = cfg.counted ? cnt_reg - 14'h0001 : cnt_reg;
          end
        end
        S_WAIT_ON: if (tmr_done) state_next = S_ON; // R10
        S_WAIT_OFF: if (tmr_done) state_next = S_IDLE; // R11 R12
        default: state_next = S_IDLE;
      endcase
    end
  end

  wire logic on_next = (state_next == S_ON) || (state_next == S_P_ON) ||
    (state_next == S_WAIT_OFF);

  // state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      tmr_reg <= 14'h0000;
      cnt_reg <= 14'h0000;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      cnt_reg <= cnt_next;
      active_reg <= on_next;
    end
  end

  // line drive by type
  assign active = active_reg;
  assign pin.pull_low = (cfg.drive == DRV_SINK && active_reg) || // R01
    (cfg.drive == DRV_BOTH && !active_reg); // R03
  assign pin.drive_high = (cfg.drive != DRV_SINK) && active_reg; // R02 R03
endmodule
`default_nettype wire

//--- hdl/pulse_seq_pkg.sv
// package: constants, types and register map of the output pulse sequencer
package pulse_seq_pkg;
  localparam int NUM_OUT = 4;
  localparam int NUM_IN = 7;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int SEC_TICKS = 1000 / TICK_MS;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ACT_W = 12'h004;
  localparam logic [11:0] OFF_INACT_W = 12'h008;
  localparam logic [11:0] OFF_DELAY = 12'h00C;
  localparam logic [11:0] OFF_COUNT = 12'h010;
  localparam logic [11:0] OFF_CMD = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [11:0] OFF_FS_CFG = 12'h01C;
  localparam logic [11:0] OFF_MAC_LO = 12'h020;
  localparam logic [11:0] OFF_MAC_HI = 12'h024;
  localparam logic [11:0] OFF_INCFG = 12'h028;
  localparam logic [11:0] OFF_CH_STRIDE = 12'h040;
  localparam logic [11:0] OFF_CH_BASE = 12'h100;
  // reset values
  localparam logic [13:0] WIDTH_RST = 14'h0001;
  localparam logic [13:0] DELAY_RST = 14'h0001;
  localparam logic [13:0] COUNT_RST = 14'h0001;
  localparam logic [13:0] FS_SEC_RST = 14'h001E;
  localparam logic [47:0] MAC_RST = 48'h0200_0000_0001; // arbitrary value
  // message constants
  localparam logic [7:0] MSG_DIGITAL = 8'h00;
  localparam logic [7:0] MSG_SERIAL = 8'h01;
  localparam int MSG_BYTES = 20;

  typedef enum logic [1:0] {DRV_SINK = 2'b00, DRV_SOURCE = 2'b01, DRV_BOTH = 2'b10} drive_t;
  typedef enum logic [1:0] {
    OUT_MANUAL = 2'b00, OUT_PULSE = 2'b01, OUT_DLY_ACT = 2'b10, OUT_DLY_DEACT = 2'b11
  } out_mode_t;
  typedef enum logic [1:0] {FS_NONE = 2'b00, FS_ACT = 2'b01, FS_DEACT = 2'b10} fs_act_t;

  // per-channel configuration
  typedef struct packed {
    drive_t drive;
    out_mode_t mode;
    logic counted;
    fs_act_t fs;
    logic follow_en;
    logic [2:0] follow_src;
    logic [13:0] act_w;
    logic [13:0] inact_w;
    logic [13:0] delay;
    logic [13:0] count;
  } ch_cfg_t;

  // pin drive of one channel: line low, line high
  typedef struct packed {
    logic pull_low;
    logic drive_high;
  } pin_drv_t;

  // status message stream byte
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } msg_byte_t;
endpackage
